// ---- hw/opi_pkg.sv ----
// constants, register map and carrier types of the output protection and indicator block
package opi_pkg;

  // ********************************************************************
  // clock and timing
  // ********************************************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned LD_DELAY_S     = 3;
  localparam int unsigned LD_DELAY_CYC   = LD_DELAY_S * CLK_HZ;
  localparam int unsigned BLINK_MS       = 250;
  localparam int unsigned BLINK_CYC      = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned BEEP_MS        = 100;
  localparam int unsigned BEEP_CYC       = BEEP_MS * (CLK_HZ / 1000);
  localparam int unsigned KNOB_FAST_MS   = 50;
  localparam int unsigned KNOB_FAST_CYC  = KNOB_FAST_MS * (CLK_HZ / 1000);
  localparam int unsigned KNOB_FSTR_MS   = 10;
  localparam int unsigned KNOB_FSTR_CYC  = KNOB_FSTR_MS * (CLK_HZ / 1000);
  localparam int unsigned SYNC_CYC       = 3;
  localparam int unsigned DLY_W          = 29;
  localparam int unsigned BLK_W          = 25;
  localparam int unsigned CNT_W          = 24;

  // ********************************************************************
  // register map (byte addresses)
  // ********************************************************************
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_LD_SP    = 8'h0C;
  localparam logic [7:0] ADDR_TEMP_SP  = 8'h10;
  localparam int unsigned CTL_LD_PRESS  = 0;
  localparam int unsigned CTL_TEC_PRESS = 1;
  localparam logic [15:0] STEP_SLOW    = 16'h0001;
  localparam logic [15:0] STEP_FAST    = 16'h000A;
  localparam logic [15:0] STEP_FSTR    = 16'h0064;
  localparam logic [15:0] SP_MAX       = 16'hFFFF;

  // ********************************************************************
  // modes and states
  // ********************************************************************
  typedef enum logic [1:0] {LDM_CUR = 2'h0, LDM_PD = 2'h1, LDM_POW = 2'h2} opi_ld_mode_e;
  typedef enum logic [1:0] {TCM_CUR = 2'h0, TCM_TEMP = 2'h1, TCM_RES = 2'h2} opi_tec_mode_e;
  typedef enum logic [2:0] {PH_LOAD = 3'h1, PH_BEEP = 3'h2, PH_RUN = 3'h4} opi_phase_e;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic [14:0]   rsvd;
    logic          knob_sel;     // 0 laser current setpoint, 1 temperature setpoint
    logic [1:0]    sensor_sel;
    logic [3:0]    ld_resp;
    opi_tec_mode_e tec_mode;
    opi_ld_mode_e  ld_mode;
    logic          ld_bw;
    logic          ld_range;
    logic          thermistor;
    logic          tec_ilk_alt;  // hardware_config_command interlock polarity
    logic          ld_tec_link;
    logic          beep_en;
  } opi_cfg_s;

  localparam opi_cfg_s CFG_RST = 32'h0000_0001;

  typedef struct packed {
    logic connected;
    logic ilk_short;
    logic open_ckt;
    logic over_cur;
    logic transient;
    logic soft_lim;
    logic rear_ilk_ok;
    logic overtemp;
  } opi_ld_in_s;

  typedef struct packed {
    logic connected;
    logic ilk_closed;
    logic open;
    logic sens_open;
    logic sens_short;
    logic temp_lim;
    logic res_lim;
    logic comp_over;
    logic cur_clamp;
    logic vlim;
    logic heat;
    logic cool;
  } opi_tec_in_s;

  typedef struct packed {
    logic ld_sw;
    logic tec_sw;
    logic knob_step;
    logic knob_up;
  } opi_panel_s;

  typedef struct packed {
    logic [15:0] ld_cur;
    logic [15:0] pd_cur;
    logic [15:0] pd_pow;
    logic [15:0] tec_cur;
    logic [15:0] tec_temp;
    logic [15:0] tec_res;
  } opi_meas_s;

  typedef struct packed {
    logic ld_drive_en;
    logic ld_on_led;
    logic ld_err_led;
    logic ld_lim_led;
    logic ld_unit_ma;
    logic ld_unit_mw;
    logic tec_drive_en;
    logic tec_on_led;
    logic tec_err_led;
    logic tec_lim_led;
    logic heat_led;
    logic cool_led;
    logic tec_unit_a;
    logic tec_unit_degc;
    logic tec_unit_kohm;
    logic beeper;
  } opi_ind_s;

endpackage

// ---- hw/opi_top.sv ----
// output protection, enable delay and indicator logic with an ahb-lite register slave
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module opi_top #(
  parameter int unsigned LD_DELAY_CYC    = opi_pkg::LD_DELAY_CYC,
  parameter int unsigned BLINK_CYC       = opi_pkg::BLINK_CYC,
  parameter int unsigned BEEP_CYC        = opi_pkg::BEEP_CYC,
  parameter int unsigned KNOB_FAST_CYC   = opi_pkg::KNOB_FAST_CYC,
  parameter int unsigned KNOB_FSTR_CYC   = opi_pkg::KNOB_FSTR_CYC
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // saved configuration store
  input  wire logic [31:0]          saved_cfg,
  output logic      [31:0]          cfg_to_save,
  // condition pins from the output stages and panel
  input  wire opi_pkg::opi_ld_in_s  ld_in,
  input  wire opi_pkg::opi_tec_in_s tec_in,
  input  wire opi_pkg::opi_panel_s  panel_in,
  input  wire opi_pkg::opi_meas_s   meas,
  // indicators, drive enables and readouts
  output opi_pkg::opi_ind_s         ind,
  output logic      [15:0]          ld_disp,
  output logic      [15:0]          tec_disp,
  output logic      [15:0]          laser_current_setpoint,
  output logic      [15:0]          temperature_setpoint
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    opi_pkg::opi_ld_in_s               ld_s1;
    opi_pkg::opi_ld_in_s               ld_s2;
    opi_pkg::opi_tec_in_s              tec_s1;
    opi_pkg::opi_tec_in_s              tec_s2;
    opi_pkg::opi_panel_s               pnl_s1;
    opi_pkg::opi_panel_s               pnl_s2;
    opi_pkg::opi_panel_s               pnl_prev;
    logic [31:0]                       sav_s1;
    logic [31:0]                       sav_s2;
    opi_pkg::opi_phase_e               phase;
    logic [opi_pkg::CNT_W-1:0]         cnt_st;
    opi_pkg::opi_cfg_s                 cfg;
    logic                              ld_on;
    logic                              ld_err;
    logic                              tec_on;
    logic                              tec_err;
    logic [opi_pkg::DLY_W-1:0]         dly;
    logic [opi_pkg::BLK_W-1:0]         cnt_bl;
    logic                              blink;
    logic [opi_pkg::CNT_W-1:0]         kint;
    logic [15:0]                       ld_sp;
    logic [15:0]                       temp_sp;
    logic [7:0]                        bus_addr;
    logic                              bus_act;
    logic                              bus_wr;
    logic                              rd_pend;
    logic [31:0]                       hrdata;
    opi_pkg::opi_ind_s                 ind;
    logic [15:0]                       ld_disp;
    logic [15:0]                       tec_disp;
  } opi_state_s;

  opi_state_s s_ff;
  opi_state_s nxt_s;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    opi_pkg::opi_ld_in_s  ld;
    opi_pkg::opi_tec_in_s tc;
    opi_pkg::opi_panel_s  pr;
    opi_pkg::opi_cfg_s    wcfg;
    logic                 run;
    logic                 wr;
    logic                 ld_press;
    logic                 tec_press;
    logic                 ld_chg;
    logic                 tec_chg;
    logic                 ld_hold;
    logic                 tec_hold;
    logic                 ld_evt;
    logic                 tec_evt;
    logic                 ld_hard;
    logic                 tec_hard;
    logic                 ilk_ok;
    logic                 kstep;
    logic [15:0]          step;
    logic [15:0]          ksp;
    logic [16:0]          sum;
    logic [16:0]          dif;
    ld        = s_ff.ld_s2;
    tc        = s_ff.tec_s2;
    pr        = s_ff.pnl_s2 & ~s_ff.pnl_prev;
    wcfg      = hwdata;
    wcfg.rsvd = '0;
    nxt_s     = s_ff;
    // pins other than meas pass two flops before use
    nxt_s.ld_s1    = ld_in;
    nxt_s.ld_s2    = s_ff.ld_s1;
    nxt_s.tec_s1   = tec_in;
    nxt_s.tec_s2   = s_ff.tec_s1;
    nxt_s.pnl_s1   = panel_in;
    nxt_s.pnl_s2   = s_ff.pnl_s1;
    nxt_s.pnl_prev = s_ff.pnl_s2;
    nxt_s.sav_s1   = saved_cfg;
    nxt_s.sav_s2   = s_ff.sav_s1;

    // power-up sequence: the drive enables and on leds stay off until the run phase
    unique case (s_ff.phase)
      opi_pkg::PH_LOAD: begin
        nxt_s.cnt_st = s_ff.cnt_st + 1'b1;
        if (s_ff.cnt_st == opi_pkg::CNT_W'(opi_pkg::SYNC_CYC)) begin
          nxt_s.cfg      = s_ff.sav_s2;
          nxt_s.cfg.rsvd = '0;
          nxt_s.cnt_st   = '0;
          nxt_s.phase    = opi_pkg::PH_BEEP;
        end
      end
      opi_pkg::PH_BEEP: begin
        nxt_s.cnt_st = s_ff.cnt_st + 1'b1;
        if (!s_ff.cfg.beep_en || s_ff.cnt_st == opi_pkg::CNT_W'(BEEP_CYC - 1)) begin
          nxt_s.cnt_st = '0;
          nxt_s.phase  = opi_pkg::PH_RUN;
        end
      end
      opi_pkg::PH_RUN: begin
        nxt_s.cnt_st = s_ff.cnt_st;
      end
    endcase
    run = (s_ff.phase == opi_pkg::PH_RUN);

    // ahb-lite: writes land in the data phase, reads take one wait state
    nxt_s.bus_act = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      nxt_s.bus_addr = haddr[7:0];
      nxt_s.bus_wr   = hwrite;
      nxt_s.rd_pend  = !hwrite;
    end
    wr = s_ff.bus_act && s_ff.bus_wr;
    if (s_ff.rd_pend) begin
      nxt_s.rd_pend = 1'b0;
      unique case (s_ff.bus_addr)
        opi_pkg::ADDR_CONFIG:  nxt_s.hrdata = s_ff.cfg;
        opi_pkg::ADDR_STATUS:  nxt_s.hrdata = 32'({s_ff.phase, s_ff.dly == opi_pkg::DLY_W'(LD_DELAY_CYC),
                                 s_ff.tec_err, s_ff.tec_on, s_ff.ld_err, s_ff.ld_on});
        opi_pkg::ADDR_LD_SP:   nxt_s.hrdata = 32'(s_ff.ld_sp);
        opi_pkg::ADDR_TEMP_SP: nxt_s.hrdata = 32'(s_ff.temp_sp);
        default:               nxt_s.hrdata = 32'h0000_0000;
      endcase
    end
    ld_chg  = 1'b0;
    tec_chg = 1'b0;
    if (wr && s_ff.bus_addr == opi_pkg::ADDR_CONFIG) begin
      nxt_s.cfg = wcfg;
      ld_chg    = (wcfg.ld_mode != s_ff.cfg.ld_mode) || (wcfg.ld_range != s_ff.cfg.ld_range) ||
                  (wcfg.ld_bw != s_ff.cfg.ld_bw) || (wcfg.ld_resp != s_ff.cfg.ld_resp);
      tec_chg   = (wcfg.tec_mode != s_ff.cfg.tec_mode) ||
                  (wcfg.sensor_sel != s_ff.cfg.sensor_sel);
    end
    ld_press  = run && (pr.ld_sw ||
                (wr && s_ff.bus_addr == opi_pkg::ADDR_CONTROL && hwdata[opi_pkg::CTL_LD_PRESS]));
    tec_press = run && (pr.tec_sw ||
                (wr && s_ff.bus_addr == opi_pkg::ADDR_CONTROL && hwdata[opi_pkg::CTL_TEC_PRESS]));

    // cooler protection
    ilk_ok   = (tc.ilk_closed == s_ff.cfg.tec_ilk_alt);
    tec_hold = tc.open || tc.sens_open || tc.sens_short ||
               ((s_ff.cfg.tec_mode == opi_pkg::TCM_RES) ? tc.res_lim : tc.temp_lim);
    tec_evt  = tec_hold || tec_chg;
    if (tec_press) begin
      if (s_ff.tec_on) begin
        nxt_s.tec_on = 1'b0;
      end else if (!tec_hold) begin
        nxt_s.tec_on  = 1'b1;
        nxt_s.tec_err = 1'b0;
      end
    end
    if (tec_evt) begin
      nxt_s.tec_err = 1'b1;
      nxt_s.tec_on  = 1'b0;
    end

    // laser protection; a cooler shutdown only counts while the cooler was on
    ld_hold = ld.open_ckt || ld.over_cur || ld.transient;
    ld_evt  = ld_hold || ld_chg || (s_ff.cfg.ld_tec_link && s_ff.tec_on && tec_evt);
    if (ld_press) begin
      if (s_ff.ld_on) begin
        nxt_s.ld_on = 1'b0;
      end else if (!ld_hold) begin
        nxt_s.ld_on  = 1'b1;
        nxt_s.ld_err = 1'b0;
      end
    end
    if (ld_evt) begin
      nxt_s.ld_err = 1'b1;
      nxt_s.ld_on  = 1'b0;
    end
    // enable delay restarts from zero after any off or error
    if (!s_ff.ld_on || s_ff.ld_err) begin
      nxt_s.dly = '0;
    end else if (s_ff.dly != opi_pkg::DLY_W'(LD_DELAY_CYC)) begin
      nxt_s.dly = s_ff.dly + 1'b1;
    end

    // blink timebase, free running
    nxt_s.cnt_bl = s_ff.cnt_bl + 1'b1;
    if (s_ff.cnt_bl == opi_pkg::BLK_W'(BLINK_CYC - 1)) begin
      nxt_s.cnt_bl = '0;
      nxt_s.blink  = !s_ff.blink;
    end

    // knob: the gap since the last detent picks the step size
    kstep = run && pr.knob_step;
    if (kstep) begin
      nxt_s.kint = '0;
    end else if (s_ff.kint != '1) begin
      nxt_s.kint = s_ff.kint + 1'b1;
    end
    if (s_ff.kint < opi_pkg::CNT_W'(KNOB_FSTR_CYC)) begin
      step = opi_pkg::STEP_FSTR;
    end else if (s_ff.kint < opi_pkg::CNT_W'(KNOB_FAST_CYC)) begin
      step = opi_pkg::STEP_FAST;
    end else begin
      step = opi_pkg::STEP_SLOW;
    end
    ksp = s_ff.cfg.knob_sel ? s_ff.temp_sp : s_ff.ld_sp;
    sum = {1'b0, ksp} + {1'b0, step};
    dif = {1'b0, ksp} - {1'b0, step};
    if (kstep) begin
      if (s_ff.pnl_s2.knob_up) begin
        ksp = sum[16] ? opi_pkg::SP_MAX : sum[15:0];
      end else begin
        ksp = dif[16] ? 16'h0000 : dif[15:0];
      end
      if (s_ff.cfg.knob_sel) begin
        nxt_s.temp_sp = ksp;
      end else begin
        nxt_s.ld_sp = ksp;
      end
    end
    // a bus write wins over a knob detent in the same cycle
    if (wr && s_ff.bus_addr == opi_pkg::ADDR_LD_SP) begin
      nxt_s.ld_sp = hwdata[15:0];
    end
    if (wr && s_ff.bus_addr == opi_pkg::ADDR_TEMP_SP) begin
      nxt_s.temp_sp = hwdata[15:0];
    end

    // indicators
    ld_hard  = ld.overtemp || !ld.rear_ilk_ok || ld.over_cur;
    tec_hard = !ilk_ok || ld.overtemp || tc.sens_short || tc.sens_open || tc.comp_over ||
               tc.temp_lim || tc.res_lim;
    nxt_s.ind.ld_drive_en   = s_ff.ld_on && !s_ff.ld_err && !ld_hard &&
                              s_ff.dly == opi_pkg::DLY_W'(LD_DELAY_CYC) &&
                              ld.connected && ld.ilk_short;
    nxt_s.ind.ld_on_led     = s_ff.ld_on;
    nxt_s.ind.ld_err_led    = s_ff.ld_err || ld_hard;
    nxt_s.ind.ld_lim_led    = ld_hard || (ld.soft_lim && s_ff.blink);
    nxt_s.ind.ld_unit_ma    = (s_ff.cfg.ld_mode == opi_pkg::LDM_CUR);
    nxt_s.ind.ld_unit_mw    = (s_ff.cfg.ld_mode == opi_pkg::LDM_POW);
    nxt_s.ind.tec_drive_en  = s_ff.tec_on && !s_ff.tec_err && tc.connected && ilk_ok;
    nxt_s.ind.tec_on_led    = s_ff.tec_on;
    nxt_s.ind.tec_err_led   = s_ff.tec_err || tec_hard;
    nxt_s.ind.tec_lim_led   = tec_hard || ((tc.cur_clamp || tc.vlim) && s_ff.blink);
    nxt_s.ind.heat_led      = s_ff.tec_on && tc.heat;
    nxt_s.ind.cool_led      = s_ff.tec_on && tc.cool;
    nxt_s.ind.tec_unit_a    = (s_ff.cfg.tec_mode == opi_pkg::TCM_CUR);
    nxt_s.ind.tec_unit_degc = (s_ff.cfg.tec_mode == opi_pkg::TCM_TEMP);
    nxt_s.ind.tec_unit_kohm = (s_ff.cfg.tec_mode == opi_pkg::TCM_RES) && s_ff.cfg.thermistor;
    nxt_s.ind.beeper        = (s_ff.phase == opi_pkg::PH_BEEP) && s_ff.cfg.beep_en;
    unique case (s_ff.cfg.ld_mode)
      opi_pkg::LDM_CUR: nxt_s.ld_disp = meas.ld_cur;
      opi_pkg::LDM_PD:  nxt_s.ld_disp = meas.pd_cur;
      opi_pkg::LDM_POW: nxt_s.ld_disp = meas.pd_pow;
      default:          nxt_s.ld_disp = 16'h0000;
    endcase
    unique case (s_ff.cfg.tec_mode)
      opi_pkg::TCM_CUR:  nxt_s.tec_disp = meas.tec_cur;
      opi_pkg::TCM_TEMP: nxt_s.tec_disp = meas.tec_temp;
      opi_pkg::TCM_RES:  nxt_s.tec_disp = meas.tec_res;
      default:           nxt_s.tec_disp = 16'h0000;
    endcase
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff       <= '0;
      s_ff.phase <= opi_pkg::PH_LOAD;
      s_ff.cfg   <= opi_pkg::CFG_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign hrdata                 = s_ff.hrdata;
  assign hreadyout              = !s_ff.rd_pend;
  assign hresp                  = 1'b0;
  assign cfg_to_save            = s_ff.cfg;
  assign ind                    = s_ff.ind;
  assign ld_disp                = s_ff.ld_disp;
  assign tec_disp               = s_ff.tec_disp;
  assign laser_current_setpoint = s_ff.ld_sp;
  assign temperature_setpoint   = s_ff.temp_sp;

endmodule

// ---- verification/opi_checker.sv ----
// concurrent checks on the outputs of the protection and indicator block
`timescale 1ns/1ps
module opi_checker #(
  parameter int unsigned LD_DELAY_CYC = 20
) (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // bus
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // indicators
  input wire opi_pkg::opi_ind_s ind
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ********************************************************************
  // helper: cycles the laser on led has been lit, restarts when it goes dark
  // ********************************************************************
  logic [31:0] on_cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      on_cnt_ff <= 32'h0;
    else
      on_cnt_ff <= ind.ld_on_led ? on_cnt_ff + 32'h1 : 32'h0;
  end
  // ********************************************************************
  // assertions
  // ********************************************************************
  a_start_off: assert property ($rose(hresetn) |-> !ind.ld_on_led && !ind.tec_on_led)
    else $error("output lit right after reset");
  a_delay_full: assert property ($rose(ind.ld_drive_en) |-> on_cnt_ff >= LD_DELAY_CYC)
    else $error("laser current before the full delay");
  a_drive_lit: assert property (ind.ld_drive_en |-> ind.ld_on_led)
    else $error("laser current without on led");
  a_ld_err_off: assert property (ind.ld_err_led ##1 ind.ld_err_led |-> !ind.ld_drive_en)
    else $error("laser driven during error");
  a_tec_err_off: assert property (ind.tec_err_led ##1 ind.tec_err_led |-> !ind.tec_drive_en)
    else $error("cooler driven during error");
  a_ld_unit_one: assert property (!(ind.ld_unit_ma && ind.ld_unit_mw))
    else $error("two laser units lit");
  a_tec_unit_one: assert property ($onehot0({ind.tec_unit_a, ind.tec_unit_degc, ind.tec_unit_kohm}))
    else $error("two cooler units lit");
  a_heat_cool_on: assert property (ind.heat_led || ind.cool_led |-> ind.tec_on_led)
    else $error("heat or cool led with cooler off");
  a_beep_once: assert property ($fell(ind.beeper) |-> !ind.beeper [*8])
    else $error("beeper sounded again");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
endmodule

bind opi_top opi_checker #(.LD_DELAY_CYC(LD_DELAY_CYC)) u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .ind(ind)
);

// ---- verification/opi_plant.sv ----
// laser load, cooler load and operator wiring seen by the block's condition pins
`timescale 1ns/1ps
module opi_plant (
  // operator commands
  input wire logic             ld_plug,
  input wire logic             tec_plug,
  input wire logic             tec_short,
  input wire logic [5:0]       ld_flt,
  input wire logic [9:0]       tec_flt,
  // condition pins
  output opi_pkg::opi_ld_in_s  ld_in,
  output opi_pkg::opi_tec_in_s tec_in
);
  // the interlock jumper sits in the laser cable, so it comes and goes with the load
  assign ld_in  = {ld_plug, ld_plug, ld_flt[5:2], !ld_flt[1], ld_flt[0]};
  assign tec_in = {tec_plug, tec_short, tec_flt};
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the protection and indicator block
`timescale 1ns/1ps
module tb;
  localparam int unsigned DLY = 20;
  localparam int unsigned BLK = 4;
  localparam int unsigned BEEP = 5;
  logic                 hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, saved_cfg = 32'hA5A0_0081;
  logic [1:0]           htrans = 2'h0;
  logic                 hreadyout, hresp, clr = 1'h0, dph_rd = 1'h0;
  opi_pkg::opi_ld_in_s  ld_in;
  opi_pkg::opi_tec_in_s tec_in;
  opi_pkg::opi_panel_s  panel_in = 4'h0;
  opi_pkg::opi_meas_s   meas = 96'h0;
  opi_pkg::opi_ind_s    ind;
  logic [15:0]          ld_disp, tec_disp, ld_sp;
  logic                 ld_plug = 1'h1, tec_plug = 1'h1, tec_short = 1'h0;
  logic [5:0]           ld_flt = 6'h0;
  logic [9:0]           tec_flt = 10'h0;
  logic [7:0]           beep_n = 8'h0, lim_n = 8'h0;
  logic [65:0]          exp_q[$];
  int                   num_errors = 0, cmp_count = 0, cyc = 0;
  string                nm[4] = '{"hrdata", "ind", "disp", "count"};
  opi_top #(.LD_DELAY_CYC(DLY), .BLINK_CYC(BLK), .BEEP_CYC(BEEP), .KNOB_FAST_CYC(40),
    .KNOB_FSTR_CYC(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .saved_cfg(saved_cfg),
    .cfg_to_save(), .ld_in(ld_in), .tec_in(tec_in), .panel_in(panel_in), .meas(meas),
    .ind(ind), .ld_disp(ld_disp), .tec_disp(tec_disp), .laser_current_setpoint(ld_sp),
    .temperature_setpoint());
  opi_plant u_plant (.ld_plug(ld_plug), .tec_plug(tec_plug), .tec_short(tec_short),
    .ld_flt(ld_flt), .tec_flt(tec_flt), .ld_in(ld_in), .tec_in(tec_in));
  always #5 hclk = ~hclk;
  // ********************************************************************
  // tasks
  // ********************************************************************
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [1:0] k, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", nm[k], exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic ex(input logic [1:0] k, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({k, m, v});
    @(posedge hclk);
  endtask
  // one single ahb-lite word transfer; for a read, d is the expected data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    if (!wr)
      exp_q.push_back({2'h0, 32'hFFFF_FFFF, d});
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
  endtask
  task automatic detent(input int gap);
    tick(gap - 2);
    panel_in.knob_step <= 1'h1;
    tick(2);
    panel_in.knob_step <= 1'h0;
  endtask
  // press with the cause still there is refused, the error outlives the cause
  task automatic recover(input logic [1:0] b, input logic held, input logic [31:0] m,
    input logic [31:0] on_v, input logic [31:0] err_v);
    if (held)
      bus(1'h1, 8'h04, {30'h0, b});
    ld_flt <= 6'h0;
    tec_flt <= 10'h002;
    tick(6);
    ex(2'h1, m, err_v);
    bus(1'h1, 8'h04, {30'h0, b});
    tick(4);
    ex(2'h1, m, on_v);
  endtask
  // ********************************************************************
  // monitor and timeout
  // ********************************************************************
  always @(posedge hclk) begin
    logic [65:0] e;
    logic [31:0] o;
    beep_n <= !hresetn ? 8'h0 : beep_n + {7'h0, ind.beeper};
    lim_n <= clr ? 8'h0 : lim_n + {7'h0, ind.ld_lim_led};
    if ((dph_rd && hreadyout) || (exp_q.size() > 0 && exp_q[0][65:64] != 2'h0)) begin
      e = exp_q.pop_front();
      case (e[65:64])
        2'h0: o = hrdata;
        2'h1: o = {16'h0, ind};
        2'h2: o = {ld_disp, tec_disp};
        default: o = {ld_sp, beep_n, lim_n};
      endcase
      chk(e[65:64], o & e[63:32], e[31:0]);
    end
    if (hreadyout)
      dph_rd <= hsel && htrans[1] && !hwrite;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    logic [15:0] r;
    r = 16'($urandom(32'h0081d08e));
    meas <= {$urandom, $urandom, $urandom};
    tick(12);
    hresetn <= 1'h1;
    tick(24);
    ex(2'h3, 32'h0000_FF00, {16'h0, 8'(BEEP), 8'h0});
    ex(2'h1, 32'h0000_C300, 32'h0);
    bus(1'h0, 8'h00, 32'h0000_0081);
    bus(1'h0, 8'h14, 32'h0);
    bus(1'h0, 8'h04, 32'h0);
    for (int i = 0; i < 4; i++) begin
      logic [1:0] md;
      md = (i > 2) ? 2'h2 : 2'(i);
      bus(1'h1, 8'h00, {22'h0, md, md, 2'h0, i == 2, 3'h0});
      tick(3);
      ex(2'h2, 32'hFFFF_FFFF, {md == 0 ? meas.ld_cur : md == 1 ? meas.pd_cur : meas.pd_pow,
        md == 0 ? meas.tec_cur : md == 1 ? meas.tec_temp : meas.tec_res});
      ex(2'h1, 32'h0000_0C0E, {20'h0, md == 0, md == 2, 6'h0, md == 0, md == 1, i == 2,
        1'h0});
    end
    ld_plug <= 1'h0;
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h04, 32'h1);
    tick(DLY + 6);
    ex(2'h1, 32'h0000_C000, 32'h0000_4000);
    ld_plug <= 1'h1;
    tick(6);
    ex(2'h1, 32'h0000_C000, 32'h0000_C000);
    bus(1'h0, 8'h08, 32'h0000_0099);
    for (int k = 0; k < 2; k++)
      bus(1'h1, 8'h04, 32'h1);
    tick(5);
    bus(1'h1, 8'h04, 32'h1);
    bus(1'h1, 8'h04, 32'h1);
    tick(DLY - 6);
    ex(2'h1, 32'h0000_8000, 32'h0);
    tick(8);
    ex(2'h1, 32'h0000_8000, 32'h0000_8000);
    for (int k = 0; k < 6; k++) begin
      if (k < 3)
        ld_flt <= 6'h20 >> k;
      else
        bus(1'h1, 8'h00, 32'h0000_0010 << ((k == 5) ? 6 : k - 3));
      tick(6);
      ex(2'h1, 32'h0000_E000, 32'h0000_2000);
      recover(2'h1, k < 3, 32'h0000_6000, 32'h0000_4000, 32'h0000_2000);
    end
    for (int k = 0; k < 2; k++) begin
      ld_flt <= 6'h01 << k;
      tick(6);
      ex(2'h1, 32'h0000_B000, 32'h0000_3000);
    end
    ld_flt <= 6'h04;
    tick(6);
    clr <= 1'h1;
    tick(1);
    clr <= 1'h0;
    tick(4 * BLK);
    ex(2'h3, 32'h0000_00FF, 32'(2 * BLK));
    ex(2'h1, 32'h0000_2000, 32'h0);
    ld_flt <= 6'h0;
    tick(6);
    ex(2'h1, 32'h0000_3000, 32'h0);
    r = 16'h0100 + (r % 16'hFD00);
    bus(1'h1, 8'h0C, {16'h0, r});
    panel_in.knob_up <= 1'h1;
    detent(50);
    detent(20);
    detent(5);
    bus(1'h0, 8'h0C, {16'h0, r + opi_pkg::STEP_SLOW + opi_pkg::STEP_FAST +
      opi_pkg::STEP_FSTR});
    bus(1'h1, 8'h0C, 32'h0000_FFFE);
    detent(50);
    detent(50);
    bus(1'h0, 8'h0C, {16'h0, opi_pkg::SP_MAX});
    ex(2'h3, 32'hFFFF_0000, {opi_pkg::SP_MAX, 16'h0});
    bus(1'h1, 8'h00, 32'h0000_0100);
    tec_flt <= 10'h002;
    bus(1'h1, 8'h04, 32'h2);
    tick(4);
    ex(2'h1, 32'h0000_03F0, 32'h0000_0320);
    for (int k = 0; k < 4; k++) begin
      tec_flt <= (10'h200 >> k) | 10'h002;
      tick(6);
      ex(2'h1, 32'h0000_03F0, 32'h0000_0080 | ((k > 0) ? 32'h40 : 32'h0));
      recover(2'h2, 1'h1, 32'h0000_0180, 32'h0000_0100, 32'h0000_0080);
    end
    bus(1'h1, 8'h00, 32'h0000_0104);
    tick(6);
    ex(2'h1, 32'h0000_03C0, 32'h0000_01C0);
    tec_short <= 1'h1;
    tec_flt <= 10'h001;
    tick(6);
    ex(2'h1, 32'h0000_03F0, 32'h0000_0310);
    saved_cfg <= 32'h0000_0102;
    hresetn <= 1'h0;
    tick(3);
    hresetn <= 1'h1;
    tick(24);
    ex(2'h3, 32'h0000_FF00, 32'h0);
    ex(2'h1, 32'h0000_C300, 32'h0);
    bus(1'h0, 8'h00, 32'h0000_0102);
    end_of_test();
  end
endmodule
